// File: mba_host.sv
`timescale 1ns/1ns
module mba_host #(
    parameter int unsigned WAIT_US    = mba_pkg::MBA_FETCH_WAIT_US,
    parameter int unsigned SAVE_LIMIT = mba_pkg::MBA_SAVE_LIMIT
) (
    input  wire logic             mclk,
    input  wire logic             rst,
    input  wire logic             psel,
    input  wire logic             penable,
    input  wire logic             pwrite,
    input  wire logic [7:0]       paddr,
    input  wire logic [31:0]      pwdata,
    output logic [31:0]           prdata,
    output logic                  pready,
    output logic                  pslverr,
    output mba_pkg::mba_cmd_t     cmd,
    output logic                  cmd_valid,
    input  wire logic             cmd_ready,
    output logic [15:0]           wr_word,
    output logic                  wr_valid,
    input  wire logic             wr_ready,
    output logic                  fetch_req,
    output logic [15:0]           fetch_addr,
    output logic [6:0]            fetch_dwords,
    input  wire logic [31:0]      fetch_data,
    input  wire logic             fetch_valid,
    input  wire logic [3:0]       axis_moving,
    input  wire logic             dev_error
);
    import mba_pkg::*;

    typedef enum logic [2:0] {
        st_idle,
        st_cmd,
        st_wdata,
        st_wait,
        st_fetch
    } mba_state_t;

    // ****************************************************************
    // registers and storage
    // ****************************************************************
    mba_state_t  state;
    logic [15:0] axis_sel;
    logic [31:0] xfer_addr;
    logic [31:0] blk_offset;
    logic [15:0] blk_size;
    logic [15:0] blk_count;
    logic [15:0] save_mask;
    logic [15:0] wbuf [0:MBA_MAX_WORDS-1];
    logic [31:0] rbuf [0:MBA_MAX_DW-1];
    logic [7:0]  wfill;
    logic [7:0]  widx;
    logic [7:0]  cmd_words;
    logic [6:0]  rfill;
    logic [6:0]  rptr;
    logic [19:0] save_count;
    logic [31:0] us_left;
    logic [4:0]  div;
    logic        tick;
    logic        done;
    logic [4:0]  err;
    logic        xfer_ok;
    logic        mask_ok;
    logic [31:0] total;
    logic [1:0]  axis_idx;
    logic        start_any;
    mba_op_t     next_op;
    logic [3:0]  next_err;
    logic        go;

    wire setup = psel && !penable;
    wire wr_en = psel && penable && pready && pwrite;
    wire rd_en = psel && penable && pready && !pwrite;
    wire ctrl_wr = wr_en && (paddr == MBA_REG_CTRL);
    wire w_hs = wr_valid && wr_ready;
    wire w_last = w_hs && (widx == cmd_words - 8'h01);

    function automatic logic mapped(input logic [7:0] a);
        return (a[1:0] == 2'b00) && (a <= MBA_REG_SAVES);
    endfunction

    mba_operand_check u_check (
        .axis    (axis_sel),
        .addr    (xfer_addr),
        .offset  (blk_offset),
        .bsize   (blk_size),
        .bcount  (blk_count),
        .mask    (save_mask),
        .xfer_ok (xfer_ok),
        .mask_ok (mask_ok),
        .total   (total)
    );

    // ****************************************************************
    // start decode and checks
    // ****************************************************************
    always_comb begin
        axis_idx  = 2'(axis_sel[1:0] - 2'b01);
        start_any = ctrl_wr && (pwdata[MBA_CTRL_READ]
                    || pwdata[MBA_CTRL_WRITE] || pwdata[MBA_CTRL_SAVE]);
        next_err  = 4'h0;
        if (pwdata[MBA_CTRL_READ]) begin
            next_op     = op_read;
            next_err[0] = !xfer_ok;                          // RL6
        end else if (pwdata[MBA_CTRL_WRITE]) begin
            next_op     = op_write;
            next_err[0] = !xfer_ok;                          // RL7
            next_err[1] = xfer_ok && axis_moving[axis_idx];  // RL9
            next_err[3] = xfer_ok && ({24'h000000, wfill} < total);
        end else begin
            next_op     = op_save;
            next_err[0] = !mask_ok;                          // RL15
            next_err[1] = |axis_moving;                      // RL17
            next_err[2] = 32'(save_count) >= SAVE_LIMIT;     // RL16
        end
        go = (state == st_idle) && start_any && (next_err == 4'h0);
    end

    // ****************************************************************
    // microsecond divider
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst || div == 5'(MBA_US_CYCLES - 1)) begin
            div <= 5'h00;
        end else begin
            div <= div + 5'h01;
        end
    end

    always_ff @(posedge mclk) begin
        tick <= !rst && (div == 5'(MBA_US_CYCLES - 1));
    end

    // ****************************************************************
    // operand registers
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            axis_sel   <= 16'h0001;
            xfer_addr  <= 32'h00000000;
            blk_offset <= 32'h00000000;
            blk_size   <= 16'h0001;
            blk_count  <= 16'h0001;
            save_mask  <= 16'h0000;
        end else if (wr_en) begin
            case (paddr)
                MBA_REG_AXIS:   axis_sel   <= pwdata[15:0];
                MBA_REG_ADDR:   xfer_addr  <= pwdata;
                MBA_REG_OFFSET: blk_offset <= pwdata;
                MBA_REG_BSIZE:  blk_size   <= pwdata[15:0];
                MBA_REG_BCOUNT: blk_count  <= pwdata[15:0];
                MBA_REG_MASK:   save_mask  <= pwdata[15:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // write word buffer
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst || (ctrl_wr && pwdata[MBA_CTRL_WCLR] && state == st_idle))
        begin
            wfill <= 8'h00;
        end else if (wr_en && paddr == MBA_REG_WDATA
                     && wfill < 8'(MBA_MAX_WORDS)) begin
            wbuf[wfill[6:0]] <= pwdata[15:0];
            wfill            <= wfill + 8'h01;
        end
    end

    // ****************************************************************
    // read result buffer
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (state == st_fetch && fetch_valid) begin
            rbuf[rfill[5:0]] <= fetch_data;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst || (go && next_op == op_read)) begin
            rptr <= 7'h00;
        end else if (rd_en && paddr == MBA_REG_RDATA && rptr < rfill) begin
            rptr <= rptr + 7'h01;
        end
    end

    // ****************************************************************
    // command sequencer
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            state        <= st_idle;
            cmd          <= '0;
            cmd_valid    <= 1'b0;
            cmd_words    <= 8'h00;
            wr_valid     <= 1'b0;
            wr_word      <= 16'h0000;
            widx         <= 8'h00;
            fetch_req    <= 1'b0;
            fetch_addr   <= MBA_FETCH_BASE;
            fetch_dwords <= 7'h00;
            rfill        <= 7'h00;
            us_left      <= 32'h00000000;
            save_count   <= 20'h00000;
            done         <= 1'b0;
            err          <= 5'h00;
        end else begin
            if (dev_error && state != st_idle) begin
                err[4] <= 1'b1;
            end
            case (state)
                st_idle: begin
                    if (start_any) begin
                        err  <= {1'b0, next_err};                 // RL20
                        done <= 1'b0;
                    end
                    if (go) begin
                        cmd.op     <= next_op;
                        cmd.axis   <= axis_sel[2:0];              // RL19
                        cmd.addr   <= xfer_addr[15:0];            // RL1
                        cmd.offset <= blk_offset[15:0];           // RL2
                        cmd.bsize  <= blk_size[7:0];              // RL3
                        cmd.bcount <= blk_count[7:0];             // RL4
                        cmd.mask   <= save_mask[3:0];             // RL15
                        cmd_words  <= total[7:0];
                        cmd_valid  <= 1'b1;
                        state      <= st_cmd;
                        if (next_op == op_read) begin
                            rfill <= 7'h00;
                        end
                    end
                end
                st_cmd: begin
                    if (cmd_ready) begin
                        cmd_valid <= 1'b0;
                        case (cmd.op)
                            op_read: begin
                                // one spare tick: the first may be partial
                                us_left <= WAIT_US + 32'h00000001; // RL11
                                state   <= st_wait;
                            end
                            op_write: begin
                                widx     <= 8'h00;
                                wr_word  <= wbuf[0];              // RL12
                                wr_valid <= 1'b1;
                                state    <= st_wdata;
                            end
                            default: begin
                                save_count <= save_count + 20'h00001;
                                done       <= 1'b1;
                                state      <= st_idle;
                            end
                        endcase
                    end
                end
                st_wdata: begin
                    if (w_last) begin
                        wr_valid <= 1'b0;
                        done     <= 1'b1;
                        state    <= st_idle;
                    end else if (w_hs) begin
                        widx    <= widx + 8'h01;
                        wr_word <= wbuf[7'(widx + 8'h01)];        // RL12
                    end
                end
                st_wait: begin
                    if (us_left == 32'h00000000) begin
                        fetch_addr   <= MBA_FETCH_BASE;           // RL10
                        fetch_dwords <= mba_dwords(cmd_words);    // RL10
                        fetch_req    <= 1'b1;
                        state        <= st_fetch;
                    end else if (tick) begin
                        us_left <= us_left - 32'h00000001;
                    end
                end
                st_fetch: begin
                    if (fetch_valid) begin
                        rfill <= rfill + 7'h01;
                        if (rfill + 7'h01 == fetch_dwords) begin
                            fetch_req <= 1'b0;
                            done      <= 1'b1;
                            state     <= st_idle;
                        end
                    end
                end
                default: state <= st_idle;
            endcase
        end
    end

    // ****************************************************************
    // apb slave
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (rst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup && !mapped(paddr);
            prdata  <= 32'h00000000;
            if (setup && !pwrite) begin
                case (paddr)
                    MBA_REG_STATUS: prdata <= {9'h000, rfill, wfill, 1'b0,
                                               err, done,
                                               state != st_idle};
                    MBA_REG_AXIS:   prdata <= {16'h0000, axis_sel};
                    MBA_REG_ADDR:   prdata <= xfer_addr;
                    MBA_REG_OFFSET: prdata <= blk_offset;
                    MBA_REG_BSIZE:  prdata <= {16'h0000, blk_size};
                    MBA_REG_BCOUNT: prdata <= {16'h0000, blk_count};
                    MBA_REG_MASK:   prdata <= {16'h0000, save_mask};
                    MBA_REG_RDATA:  prdata <= (rptr < rfill)
                                              ? rbuf[rptr[5:0]]
                                              : 32'h00000000;
                    MBA_REG_SAVES:  prdata <= {12'h000, save_count};
                    default:        prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    logic [31:0] since_cmd;
    always_ff @(posedge mclk) begin
        if (rst || (cmd_valid && cmd_ready)) begin
            since_cmd <= 32'h00000000;
        end else if (since_cmd != 32'hFFFFFFFF) begin
            since_cmd <= since_cmd + 32'h00000001;
        end
    end

    property p_addr;
        @(posedge mclk) disable iff (rst)
        cmd_valid && cmd.op != op_save |-> 32'(cmd.addr) <= MBA_ADDR_MAX;
    endproperty
    a_addr: assert property (p_addr) else $error("bad address"); // RL1

    property p_offset;
        @(posedge mclk) disable iff (rst)
        cmd_valid && cmd.op != op_save
        |-> 32'(cmd.offset) <= MBA_ADDR_MAX;
    endproperty
    a_offset: assert property (p_offset) else $error("bad offset"); // RL2

    property p_bsize;
        @(posedge mclk) disable iff (rst)
        cmd_valid && cmd.op != op_save
        |-> cmd.bsize != 8'h00 && cmd.bsize <= 8'h80;
    endproperty
    a_bsize: assert property (p_bsize) else $error("bad size"); // RL3

    property p_bcount;
        @(posedge mclk) disable iff (rst)
        cmd_valid && cmd.op != op_save
        |-> cmd.bcount != 8'h00 && cmd.bcount <= 8'h80;
    endproperty
    a_bcount: assert property (p_bcount) else $error("bad count"); // RL4

    property p_rd_total;
        @(posedge mclk) disable iff (rst)
        cmd_valid && cmd.op == op_read
        |-> 16'(cmd.bsize) * 16'(cmd.bcount) <= 16'h0080;
    endproperty
    a_rd_total: assert property (p_rd_total) // RL6
        else $error("read too big");

    property p_wr_total;
        @(posedge mclk) disable iff (rst)
        cmd_valid && cmd.op == op_write
        |-> 16'(cmd.bsize) * 16'(cmd.bcount) <= 16'h0080;
    endproperty
    a_wr_total: assert property (p_wr_total) // RL7
        else $error("write too big");

    property p_axis;
        @(posedge mclk) disable iff (rst)
        cmd_valid && cmd.op != op_save
        |-> cmd.axis >= 3'h1 && cmd.axis <= 3'h4;
    endproperty
    a_axis: assert property (p_axis) else $error("bad axis"); // RL19

    property p_wr_idle;
        @(posedge mclk) disable iff (rst)
        $rose(cmd_valid) && cmd.op == op_write
        |-> ($past(axis_moving) & (4'h1 << (cmd.axis - 3'h1))) == 4'h0;
    endproperty
    a_wr_idle: assert property (p_wr_idle) else $error("write moving"); // RL9

    property p_save_idle;
        @(posedge mclk) disable iff (rst)
        $rose(cmd_valid) && cmd.op == op_save
        |-> $past(axis_moving) == 4'h0 && cmd.mask != 4'h0;
    endproperty
    a_save_idle: assert property (p_save_idle) // RL17
        else $error("save moving");

    property p_save_limit;
        @(posedge mclk) disable iff (rst)
        $rose(cmd_valid) && cmd.op == op_save
        |-> 32'(save_count) < SAVE_LIMIT;
    endproperty
    a_save_limit: assert property (p_save_limit) // RL16
        else $error("wear limit");

    property p_fetch_wait;
        @(posedge mclk) disable iff (rst)
        $rose(fetch_req) |-> since_cmd >= WAIT_US * MBA_US_CYCLES
                             && fetch_addr == MBA_FETCH_BASE;
    endproperty
    a_fetch_wait: assert property (p_fetch_wait) // RL11
        else $error("early fetch");

    property p_word_order;
        @(posedge mclk) disable iff (rst)
        wr_valid && wr_ready && !w_last
        |=> wr_valid && wr_word == wbuf[7'(widx)]
            && widx == $past(widx) + 8'h01;
    endproperty
    a_word_order: assert property (p_word_order) // RL12
        else $error("word order");

endmodule

// File: mba_pkg.sv
// Function
// [RL1] read start address within 0 to 49586
// [RL2] block offset within 0 to 49586
// [RL3] block size 1 to 128 words
// [RL4] block count 1 to 128
// [RL5] device strides blocks by block offset
// [RL6] read total words at most 128
// [RL7] write total words at most 128
// [RL8] device serves reads during axis motion
// [RL9] no write while target axis moves
// [RL10] fetch results from common area h280
// [RL11] wait 5 ms before fetching read result
// [RL12] write words sent in order from head
// [RL13] device keeps written values until power-off
// [RL14] device saves selected axes to non-volatile memory
// [RL15] save mask bits 0-3 select axes
// [RL16] save requests limited to 1,000,000 lifetime
// [RL17] no save while any axis moves
// [RL18] device commits written cam data on save
// [RL19] axis operand must be 1 to 4
// [RL20] device rejects bad operands, flags error
// [RL21] device signals read completion
package mba_pkg;

    // ****************************************************************
    // operand limits
    // ****************************************************************
    localparam logic [31:0] MBA_ADDR_MAX  = 32'h0000C1B2;
    localparam logic [15:0] MBA_BLK_MAX   = 16'h0080;
    localparam logic [31:0] MBA_WORDS_MAX = 32'h00000080;
    localparam logic [15:0] MBA_AXIS_MAX  = 16'h0004;
    localparam int          MBA_MAX_WORDS = 128;
    localparam int          MBA_MAX_DW    = 64;
    localparam logic [15:0] MBA_FETCH_BASE = 16'h0280;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int MBA_CLK_HZ          = 25000000;
    localparam int MBA_FETCH_WAIT_MS   = 5;
    localparam int MBA_US_CYCLES       = MBA_CLK_HZ / 1000000;
    localparam int MBA_FETCH_WAIT_US   = MBA_FETCH_WAIT_MS * 1000;
    localparam int MBA_SAVE_LIMIT      = 1000000;

    // ****************************************************************
    // register map (byte offsets)
    // ****************************************************************
    localparam logic [7:0] MBA_REG_CTRL   = 8'h00;
    localparam logic [7:0] MBA_REG_STATUS = 8'h04;
    localparam logic [7:0] MBA_REG_AXIS   = 8'h08;
    localparam logic [7:0] MBA_REG_ADDR   = 8'h0C;
    localparam logic [7:0] MBA_REG_OFFSET = 8'h10;
    localparam logic [7:0] MBA_REG_BSIZE  = 8'h14;
    localparam logic [7:0] MBA_REG_BCOUNT = 8'h18;
    localparam logic [7:0] MBA_REG_MASK   = 8'h1C;
    localparam logic [7:0] MBA_REG_WDATA  = 8'h20;
    localparam logic [7:0] MBA_REG_RDATA  = 8'h24;
    localparam logic [7:0] MBA_REG_SAVES  = 8'h28;

    localparam int MBA_CTRL_READ  = 0;
    localparam int MBA_CTRL_WRITE = 1;
    localparam int MBA_CTRL_SAVE  = 2;
    localparam int MBA_CTRL_WCLR  = 3;

    typedef enum logic [1:0] {
        op_read,
        op_write,
        op_save
    } mba_op_t;

    typedef struct packed {
        mba_op_t     op;
        logic [2:0]  axis;
        logic [15:0] addr;
        logic [15:0] offset;
        logic [7:0]  bsize;
        logic [7:0]  bcount;
        logic [3:0]  mask;
    } mba_cmd_t;

    function automatic logic [6:0] mba_dwords(input logic [7:0] words);
        logic [8:0] sum;
        sum = {1'b0, words} + 9'h001;
        return sum[7:1];
    endfunction

endpackage

// File: mba_operand_check.sv
`timescale 1ns/1ns
module mba_operand_check (
    input  wire logic [15:0] axis,
    input  wire logic [31:0] addr,
    input  wire logic [31:0] offset,
    input  wire logic [15:0] bsize,
    input  wire logic [15:0] bcount,
    input  wire logic [15:0] mask,
    output logic             xfer_ok,
    output logic             mask_ok,
    output logic [31:0]      total
);
    import mba_pkg::*;

    always_comb begin
        total   = bsize * bcount;
        xfer_ok = (axis != 16'h0000) && (axis <= MBA_AXIS_MAX) // RL19
               && (addr <= MBA_ADDR_MAX)                       // RL1
               && (offset <= MBA_ADDR_MAX)                     // RL2
               && (bsize != 16'h0000) && (bsize <= MBA_BLK_MAX) // RL3
               && (bcount != 16'h0000) && (bcount <= MBA_BLK_MAX) // RL4
               && (total <= MBA_WORDS_MAX);                    // RL6
        mask_ok = (mask[15:4] == 12'h000) && (mask[3:0] != 4'h0); // RL15
    end

endmodule

// File: mba_dev_model.sv
`timescale 1ns/1ns
module mba_dev_model (
    input  wire mba_pkg::mba_cmd_t cmd,
    input  wire logic              mclk,
    input  wire logic              cmd_valid,
    output logic                   cmd_ready,
    input  wire logic [15:0]       wr_word,
    input  wire logic              wr_valid,
    output logic                   wr_ready,
    input  wire logic              fetch_req,
    input  wire logic [15:0]       fetch_addr,
    input  wire logic [6:0]        fetch_dwords,
    output logic [31:0]            fetch_data,
    output logic                   fetch_valid,
    output logic                   dev_error
);
    import mba_pkg::*;
    // ****
    // device memory and command log
    // ****
    logic [15:0] mem [0:65535];
    mba_cmd_t    last;
    logic [6:0]  ndw;
    int          ncmd = 0;
    int          k    = 0;
    int          gap  = 0;
    int          wgap = 0;
    int          nbad = 0;
    function automatic int wa(input int i);
        return last.addr + (i / last.bsize) * last.offset
               + i % last.bsize;
    endfunction
    // fault on a command aimed at the top word
    assign dev_error = cmd_valid && cmd_ready
                       && 32'(cmd.addr) == MBA_ADDR_MAX;
    initial begin
        cmd_ready = 1'b0;
        wr_ready = 1'b0;
        fetch_valid = 1'b0;
        fetch_data = 32'h0;
    end
    always @(posedge mclk) begin
        cmd_ready <= cmd_valid && !cmd_ready;
        wr_ready <= !wr_ready;
        gap <= gap + 1;
        if (cmd_valid && cmd_ready) begin
            last <= cmd;
            ncmd <= ncmd + 1;
            k <= 0;
            gap <= 0;
        end
        if (wr_valid && wr_ready) begin
            mem[wa(k)] <= wr_word;
            k <= k + 1;
        end
        if (fetch_req && fetch_addr !== MBA_FETCH_BASE)
            nbad <= nbad + 1;
        if (fetch_req && !fetch_valid && k < fetch_dwords) begin
            fetch_data <= {mem[wa(2 * k + 1)], mem[wa(2 * k)]};
            fetch_valid <= 1'b1;
            ndw <= fetch_dwords;
            k <= k + 1;
            if (k == 0)
                wgap <= gap;
        end else begin
            fetch_valid <= 1'b0;
            fetch_data <= ~fetch_data;
        end
    end
endmodule

// File: tb_top.sv
`timescale 1ns/1ns
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("wrong value %s exp %0h got %0h", n, e, g); \
    end end
module tb_top;
    import mba_pkg::*;
    logic        mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
    logic [7:0]  paddr = 0;
    logic [31:0] pwdata = 0, prdata, fetch_data, rq;
    logic        re, pready, pslverr, cmd_valid, cmd_ready, wr_valid;
    logic        wr_ready, fetch_req, fetch_valid, dev_error;
    logic [15:0] wr_word, fetch_addr;
    logic [6:0]  fetch_dwords;
    logic [3:0]  axis_moving = 0;
    mba_cmd_t    cmd;
    int          n_mismatch = 0, num_checks = 0, n0;
    int          ax[11] = '{0, 5, 1, 1, 1, 1, 1, 1, 1, 1, 1};
    int          ad[11] = '{0, 0, 49587, 0, 0, 0, 0, 0, 49586, 0, 0};
    int          of[11] = '{0, 0, 0, 49587, 0, 0, 0, 0, 0, 0, 0};
    int          bs[11] = '{1, 1, 1, 1, 0, 129, 16, 11, 1, 1, 1};
    int          bc[11] = '{1, 1, 1, 1, 1, 1, 8, 12, 128, 0, 129};
    bit [10:0]   er     = 11'h6BF;
    always #20 mclk = ~mclk;
    mba_host #(.WAIT_US(4), .SAVE_LIMIT(3)) uut (.mclk, .rst, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .cmd, .cmd_valid, .cmd_ready, .wr_word, .wr_valid, .wr_ready,
        .fetch_req, .fetch_addr, .fetch_dwords, .fetch_data, .fetch_valid,
        .axis_moving, .dev_error);
    mba_dev_model dev (.mclk, .cmd, .cmd_valid, .cmd_ready, .wr_word,
        .wr_valid, .wr_ready, .fetch_req, .fetch_addr, .fetch_dwords,
        .fetch_data, .fetch_valid, .dev_error);
    // ****
    // bus tasks
    // ****
    task automatic complete_run();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int i;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge mclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rq = prdata;
        re = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
        if (i >= 20) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic go(input int b);
        int i;
        apb(1, MBA_REG_CTRL, 32'h1 << b);
        i = 0;
        do begin
            apb(0, MBA_REG_STATUS, 0);
            i++;
        end while (rq[0] === 1'b1 && i < 200);
        if (i >= 200) begin
            n_mismatch++;
            complete_run();
        end
    endtask
    task automatic setop(input int a, b, c, d, e);
        int v[5];
        v = '{a, b, c, d, e};
        for (int j = 0; j < 5; j++)
            apb(1, MBA_REG_AXIS + 8'(4 * j), v[j]);
    endtask
    initial begin
        repeat (100000) @(posedge mclk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        apb(0, MBA_REG_BSIZE, 0);
        `CHK("bsize reset", 32'h1, rq)
        apb(0, 8'h3C, 0);
        `CHK("unmapped", 1'b1, re)
        setop(1, 10, 20, 2, 2);
        for (int j = 0; j < 4; j++)
            apb(1, MBA_REG_WDATA, 32'hA1 + j);
        go(1);
        `CHK("write status", 6'h02, rq[5:0])
        for (int j = 0; j < 4; j++)
            `CHK("mem", 16'hA1 + j, dev.mem[10 + j / 2 * 20 + j % 2])
        axis_moving <= 4'h1;
        n0 = dev.ncmd;
        go(1);
        `CHK("moving write", 1'b1, rq[3])
        `CHK("no command", n0, dev.ncmd)
        go(0);
        `CHK("moving read", 6'h02, rq[5:0])
        `CHK("fetch wait", 1'b1, dev.wgap >= 100)
        `CHK("dwords", 7'h2, dev.ndw)
        `CHK("fetch addr", 0, dev.nbad)
        apb(0, MBA_REG_RDATA, 0);
        `CHK("rdata0", 32'h00A200A1, rq)
        apb(0, MBA_REG_RDATA, 0);
        `CHK("rdata1", 32'h00A400A3, rq)
        axis_moving <= 4'h0;
        n0 = dev.ncmd;
        for (int i = 0; i < 11; i++) begin
            setop(ax[i], ad[i], of[i], bs[i], bc[i]);
            go(0);
            `CHK("range", er[i], rq[2])
            `CHK("device error", i == 8, rq[6])
        end
        `CHK("commands", n0 + 2, dev.ncmd)
        setop(1, 0, 0, 11, 12);
        go(1);
        `CHK("write total", 1'b1, rq[2])
        apb(1, MBA_REG_CTRL, 32'h8);
        setop(1, 0, 0, 2, 1);
        go(1);
        `CHK("short buffer", 11'h001, rq[15:5])
        axis_moving <= 4'h8;
        apb(1, MBA_REG_MASK, 3);
        go(2);
        `CHK("moving save", 1'b1, rq[3])
        axis_moving <= 4'h0;
        apb(1, MBA_REG_MASK, 32'h10);
        go(2);
        `CHK("mask", 1'b1, rq[2])
        for (int j = 0; j < 3; j++) begin
            apb(1, MBA_REG_MASK, 32'hF >> j);
            go(2);
            `CHK("saved", 4'hF >> j, dev.last.mask)
        end
        apb(0, MBA_REG_SAVES, 0);
        `CHK("saves", 32'h3, rq)
        go(2);
        `CHK("save limit", 1'b1, rq[4])
        complete_run();
    end
endmodule
